// file: hw/tmr_pkg.sv
package tmr_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_COUNT = 8'h04;
   localparam logic [7:0] OFS_CMPA = 8'h08;
   localparam logic [7:0] OFS_CMPB = 8'h0C;
   localparam logic [7:0] OFS_FLAGS = 8'h10;
   localparam logic [7:0] OFS_FORCE = 8'h14;
   localparam logic [7:0] OFS_PORT = 8'h18;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_W = 10;
   localparam int FLG_OVF = 0;
   localparam int FLG_CMPA = 1;
   localparam int FLG_CMPB = 2;
   localparam int FRC_A = 0;
   localparam int FRC_B = 1;
   localparam int PRT_DATA = 0;
   localparam int PRT_DIR = 4;

   // ----------------------------------------------------------------
   // Reset values and constants
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [9:0] PRE_RST = 10'h000;
   localparam logic [31:0] RD_ZERO = 32'h00000000;

   // Prescaler divide masks (tick when low bits all ones)
   localparam logic [9:0] DIV8_M = 10'h007;
   localparam logic [9:0] DIV64_M = 10'h03F;
   localparam logic [9:0] DIV256_M = 10'h0FF;
   localparam logic [9:0] DIV1024_M = 10'h3FF;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      WGM_NORMAL = 3'b000,
      WGM_PC_FF = 3'b001,
      WGM_CLEAR_ON_MATCH = 3'b010,
      WGM_FAST_FF = 3'b011,
      WGM_RSV4 = 3'b100,
      WGM_PC_TOP = 3'b101,
      WGM_RSV6 = 3'b110,
      WGM_FAST_TOP = 3'b111
   } tmr_wgm_t;

   typedef enum logic [2:0] {
      CS_STOP = 3'b000,
      CS_DIV1 = 3'b001,
      CS_DIV8 = 3'b010,
      CS_DIV64 = 3'b011,
      CS_DIV256 = 3'b100,
      CS_DIV1024 = 3'b101,
      CS_EXT_FALL = 3'b110,
      CS_EXT_RISE = 3'b111
   } tmr_cs_t;

   typedef enum logic [1:0] {
      COM_HOLD = 2'b00,
      COM_TOGGLE = 2'b01,
      COM_CLEAR = 2'b10,
      COM_SET = 2'b11
   } tmr_com_t;

   // Control register layout, msb first
   typedef struct packed {
      tmr_cs_t clock_select;
      tmr_wgm_t waveform_mode;
      tmr_com_t compare_b_output_mode;
      tmr_com_t compare_a_output_mode;
   } tmr_ctrl_t;

   localparam tmr_ctrl_t CTRL_RST = '{CS_STOP, WGM_NORMAL,
                                      COM_HOLD, COM_HOLD};

endpackage

// file: hw/tmr_timer8.sv
`timescale 1ns/1ns
// How it works
// (RULE1) A counter write blocks every compare match at the next tick.
// (RULE2) Output mode bits act directly, at the first match after writing.
// (RULE3) Output state registers keep value across waveform mode changes.
// (RULE4) Reset clears both output state registers to zero.
// (RULE5) Nonzero output mode puts output state on the pin, not port data.
// (RULE6) Pin is driven only when its direction bit selects output.
// (RULE7) Pin override ignores the waveform mode.
// (RULE8) Output mode zero leaves the output state unchanged on a match.
// (RULE9) Force strobe in non-PWM modes applies the match action at once.
// (RULE10) Only waveform mode chooses the count sequence.
// (RULE11) Non-PWM: set, clear or toggle on match; PWM: polarity choice; here PWM modes hold the state.
// (RULE12) Mode 0 counts up always and wraps 0xFF to 0x00.
// (RULE13) Normal mode sets overflow flag on the tick reaching zero.
// (RULE14) Normal mode accepts a counter write at any time.
// (RULE15) Mode 2 clears the counter when it matches compare A.
// (RULE16) Compare A unbuffered; a missed top runs through 0xFF first.
// (RULE17) Clear-on-match sets compare A flag at every top.
// (RULE18) Toggle mode flips output A on every clear-on-match top.
// (RULE19) Toggle rate is clock over 2 times prescale times one plus top.
// (RULE20) Clear-on-match sets overflow flag when passing max to zero.
// (RULE21) Software avoids writing the counter equal to a compare value.
// (RULE22) Software sets output state before turning the pin to output.
// (RULE23) Match sets flag on tick; ack or writing one clears it.
// (RULE24) A counter write beats clear or count in the same cycle.
// (RULE25) Compare writes go straight to the active compare registers.
// (RULE26) Forced compare sets no flag and leaves the counter alone.
// (RULE27) All updates are on hclk, qualified by a one-cycle tick; here bus writes, flag clears and the prescaler update without a tick.
module tmr_timer8 (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic ext_clk_in,
   input wire logic [2:0] flag_ack,
   output logic timer_tick,
   output logic pin_a_out,
   output logic pin_a_oe,
   output logic pin_b_out,
   output logic pin_b_oe
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------

   // Next output state for a match or force under a given mode
   function automatic logic com_next(input tmr_pkg::tmr_com_t com,
                                     input logic cur);
      case (com)
         tmr_pkg::COM_TOGGLE: com_next = ~cur;
         tmr_pkg::COM_CLEAR: com_next = 1'b0;
         tmr_pkg::COM_SET: com_next = 1'b1;
         default: com_next = cur; // see (RULE8)
      endcase
   endfunction

   // PWM modes have an odd mode code
   function automatic logic is_pwm(input tmr_pkg::tmr_wgm_t w);
      is_pwm = w[0];
   endfunction

   // ----------------------------------------------------------------
   // Registers and wires
   // ----------------------------------------------------------------
   tmr_pkg::tmr_ctrl_t ctrl_ff;
   logic [7:0] counter_value_ff;
   logic [7:0] compare_a_value_ff;
   logic [7:0] compare_b_value_ff;
   logic [2:0] flags_ff;
   logic [1:0] port_data_ff;
   logic [1:0] compare_pin_direction_ff;
   logic [1:0] compare_output_state_ff;
   logic block_ff;
   logic [9:0] pre_ff;
   logic ext_ff;
   logic ext_old_ff;
   logic [7:0] addr_ff;
   logic wr_ff;
   logic [31:0] nxt_rdata;
   logic nxt_tick;
   logic [7:0] nxt_count;
   logic [1:0] nxt_oc;
   logic wr_ctrl;
   logic wr_count;
   logic wr_cmpa;
   logic wr_cmpb;
   logic wr_flags;
   logic wr_force;
   logic wr_port;
   logic addr_phase;
   logic match_a;
   logic match_b;
   logic ovf_evt;
   logic cmpa_evt;
   logic cmpb_evt;
   logic ctc_mode;

   // ----------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------

   // Address phase taken when selected, active and bus ready
   assign addr_phase = hsel & htrans[1] & hready;

   // Zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Capture address phase for the data phase write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_ff <= tmr_pkg::RST_BYTE;
         wr_ff <= 1'b0;
      end else begin
         if (hready) begin
            addr_ff <= haddr[7:0];
            wr_ff <= addr_phase & hwrite & (haddr[31:8] == 24'h000000);
         end
      end
   end

   // Write strobes, valid in the data phase
   assign wr_ctrl = wr_ff & (addr_ff == tmr_pkg::OFS_CTRL);
   assign wr_count = wr_ff & (addr_ff == tmr_pkg::OFS_COUNT);
   assign wr_cmpa = wr_ff & (addr_ff == tmr_pkg::OFS_CMPA);
   assign wr_cmpb = wr_ff & (addr_ff == tmr_pkg::OFS_CMPB);
   assign wr_flags = wr_ff & (addr_ff == tmr_pkg::OFS_FLAGS);
   assign wr_force = wr_ff & (addr_ff == tmr_pkg::OFS_FORCE);
   assign wr_port = wr_ff & (addr_ff == tmr_pkg::OFS_PORT);

   // Read mux sampled in the address phase; unmapped reads zero
   always_comb begin
      nxt_rdata = tmr_pkg::RD_ZERO;
      if (haddr[31:8] != 24'h000000) begin
         nxt_rdata = tmr_pkg::RD_ZERO;
      end else if (haddr[7:0] == tmr_pkg::OFS_CTRL) begin
         nxt_rdata[tmr_pkg::CTRL_W-1:0] = ctrl_ff;
      end else if (haddr[7:0] == tmr_pkg::OFS_COUNT) begin
         nxt_rdata[7:0] = counter_value_ff;
      end else if (haddr[7:0] == tmr_pkg::OFS_CMPA) begin
         nxt_rdata[7:0] = compare_a_value_ff;
      end else if (haddr[7:0] == tmr_pkg::OFS_CMPB) begin
         nxt_rdata[7:0] = compare_b_value_ff;
      end else if (haddr[7:0] == tmr_pkg::OFS_FLAGS) begin
         nxt_rdata[2:0] = flags_ff;
      end else if (haddr[7:0] == tmr_pkg::OFS_FORCE) begin
         nxt_rdata[1:0] = compare_output_state_ff;
      end else if (haddr[7:0] == tmr_pkg::OFS_PORT) begin
         nxt_rdata[tmr_pkg::PRT_DATA+:2] = port_data_ff;
         nxt_rdata[tmr_pkg::PRT_DIR+:2] = compare_pin_direction_ff;
      end
   end

   // Read data register; a write in the previous data phase is not
   // yet visible to a read issued back to back at the same address
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= tmr_pkg::RD_ZERO;
      end else if (addr_phase & ~hwrite) begin
         hrdata <= nxt_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------

   // Output mode bits take effect at once, no buffering (see (RULE2))
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= tmr_pkg::CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_ff <= tmr_pkg::tmr_ctrl_t'(hwdata[tmr_pkg::CTRL_W-1:0]);
      end
   end

   // Compare values written straight to the active copy (see (RULE25))
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         compare_a_value_ff <= tmr_pkg::RST_BYTE;
         compare_b_value_ff <= tmr_pkg::RST_BYTE;
      end else begin
         if (wr_cmpa) begin
            compare_a_value_ff <= hwdata[7:0]; // see (RULE16)
         end
         if (wr_cmpb) begin
            compare_b_value_ff <= hwdata[7:0];
         end
      end
   end

   // Port data and direction bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_data_ff <= 2'h0;
         compare_pin_direction_ff <= 2'h0;
      end else if (wr_port) begin
         port_data_ff <= hwdata[tmr_pkg::PRT_DATA+:2];
         compare_pin_direction_ff <= hwdata[tmr_pkg::PRT_DIR+:2];
      end
   end

   // ----------------------------------------------------------------
   // Clock select and prescaler
   // ----------------------------------------------------------------

   // Free-running prescaler; not reset on clock select changes, so
   // the first prescaled tick may come early
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_ff <= tmr_pkg::PRE_RST;
      end else begin
         pre_ff <= pre_ff + 10'h001;
      end
   end

   // External clock level, taken as synchronous to hclk
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_ff <= 1'b0;
         ext_old_ff <= 1'b0;
      end else begin
         ext_ff <= ext_clk_in;
         ext_old_ff <= ext_ff;
      end
   end

   // One-cycle tick from the selected source (see (RULE19))
   always_comb begin
      case (ctrl_ff.clock_select)
         tmr_pkg::CS_DIV1: nxt_tick = 1'b1;
         tmr_pkg::CS_DIV8:
            nxt_tick = &(pre_ff | ~tmr_pkg::DIV8_M);
         tmr_pkg::CS_DIV64:
            nxt_tick = &(pre_ff | ~tmr_pkg::DIV64_M);
         tmr_pkg::CS_DIV256:
            nxt_tick = &(pre_ff | ~tmr_pkg::DIV256_M);
         tmr_pkg::CS_DIV1024:
            nxt_tick = &(pre_ff | ~tmr_pkg::DIV1024_M);
         tmr_pkg::CS_EXT_FALL: nxt_tick = ext_old_ff & ~ext_ff;
         tmr_pkg::CS_EXT_RISE: nxt_tick = ~ext_old_ff & ext_ff;
         default: nxt_tick = 1'b0;
      endcase
   end

   // Tick register, the timer's clock enable (see (RULE27))
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_tick <= 1'b0;
      end else begin
         timer_tick <= nxt_tick;
      end
   end

   // ----------------------------------------------------------------
   // Counter unit
   // ----------------------------------------------------------------
   assign ctc_mode =
      (ctrl_ff.waveform_mode == tmr_pkg::WGM_CLEAR_ON_MATCH);
   assign match_a = (counter_value_ff == compare_a_value_ff);
   assign match_b = (counter_value_ff == compare_b_value_ff);

   // Sequence chosen by waveform mode alone (see (RULE10))
   always_comb begin
      nxt_count = counter_value_ff;
      if (wr_count) begin
         nxt_count = hwdata[7:0]; // see (RULE24) (RULE14)
      end else if (timer_tick) begin
         if (ctc_mode & match_a) begin
            nxt_count = tmr_pkg::CNT_BOTTOM; // see (RULE15)
         end else begin
            nxt_count = counter_value_ff + 8'h01; // see (RULE12)
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         counter_value_ff <= tmr_pkg::RST_BYTE;
      end else begin
         counter_value_ff <= nxt_count;
      end
   end

   // Block flag: armed by a counter write, spent by the next tick,
   // held across a stopped clock (see (RULE1))
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         block_ff <= 1'b0;
      end else if (wr_count) begin
         block_ff <= 1'b1;
      end else if (timer_tick) begin
         block_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------

   // Overflow when passing max to zero (see (RULE13) (RULE20))
   assign ovf_evt = timer_tick & ~wr_count &
      (counter_value_ff == tmr_pkg::CNT_MAX);
   assign cmpa_evt = timer_tick & ~block_ff & match_a; // see (RULE17)
   assign cmpb_evt = timer_tick & ~block_ff & match_b;

   // Set wins over write-one clear or acknowledge (see (RULE23))
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_ff <= 3'h0;
      end else begin
         flags_ff[tmr_pkg::FLG_OVF] <= ovf_evt |
            (flags_ff[tmr_pkg::FLG_OVF] &
             ~(flag_ack[tmr_pkg::FLG_OVF] |
               (wr_flags & hwdata[tmr_pkg::FLG_OVF])));
         flags_ff[tmr_pkg::FLG_CMPA] <= cmpa_evt |
            (flags_ff[tmr_pkg::FLG_CMPA] &
             ~(flag_ack[tmr_pkg::FLG_CMPA] |
               (wr_flags & hwdata[tmr_pkg::FLG_CMPA])));
         flags_ff[tmr_pkg::FLG_CMPB] <= cmpb_evt |
            (flags_ff[tmr_pkg::FLG_CMPB] &
             ~(flag_ack[tmr_pkg::FLG_CMPB] |
               (wr_flags & hwdata[tmr_pkg::FLG_CMPB])));
      end
   end

   // ----------------------------------------------------------------
   // Compare output state
   // ----------------------------------------------------------------

   // Match or force applies the mode action; force touches neither
   // flag nor counter. PWM waveforms are not built here, so PWM
   // modes hold the state (see (RULE11) (RULE26))
   always_comb begin
      nxt_oc = compare_output_state_ff;
      if (!is_pwm(ctrl_ff.waveform_mode)) begin
         if (cmpa_evt | (wr_force & hwdata[tmr_pkg::FRC_A])) begin
            nxt_oc[0] = com_next(ctrl_ff.compare_a_output_mode,
               compare_output_state_ff[0]); // see (RULE9) (RULE18)
         end
         if (cmpb_evt | (wr_force & hwdata[tmr_pkg::FRC_B])) begin
            nxt_oc[1] = com_next(ctrl_ff.compare_b_output_mode,
               compare_output_state_ff[1]); // see (RULE9)
         end
      end
   end

   // Zeroed by reset, otherwise loaded from nxt_oc; kept across mode changes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         compare_output_state_ff <= 2'h0; // see (RULE4)
      end else begin
         compare_output_state_ff <= nxt_oc; // see (RULE3)
      end
   end

   // ----------------------------------------------------------------
   // Pin override
   // ----------------------------------------------------------------

   // Source picked by output mode only, direction by the port bit;
   // registered from nxt_oc, so pins change on the same edge as the state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_a_out <= 1'b0;
         pin_b_out <= 1'b0;
         pin_a_oe <= 1'b0;
         pin_b_oe <= 1'b0;
      end else begin
         pin_a_out <= (|ctrl_ff.compare_a_output_mode) ?
            nxt_oc[0] : port_data_ff[0]; // see (RULE5) (RULE7)
         pin_b_out <= (|ctrl_ff.compare_b_output_mode) ?
            nxt_oc[1] : port_data_ff[1]; // see (RULE5) (RULE7)
         pin_a_oe <= compare_pin_direction_ff[0]; // see (RULE6)
         pin_b_oe <= compare_pin_direction_ff[1]; // see (RULE6)
      end
   end

endmodule

// file: verif/tb.sv
`timescale 1ns/1ns
module tb;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize, flag_ack;
   logic ext_clk_in, timer_tick, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
   int errors = 0, comparisons = 0, gap, cmp;
   logic [31:0] exp_q[$];
   logic rd_dp_ff;
   logic [1:0] st;
   logic [1:0] codes [5] = '{2'd3, 2'd2, 2'd1, 2'd0, 2'd1};
   logic [7:0] offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                            8'h18, 8'h20};

   tmr_timer8 tmr_timer8_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
      .ext_clk_in, .flag_ack, .timer_tick, .pin_a_out, .pin_a_oe,
      .pin_b_out, .pin_b_oe);

   // One slave: its ready is the bus ready
   assign hready = hreadyout;

   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   // -------------------------------------------------------------
   // Checking and closing
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask

   task automatic report_and_stop();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Bounded wait for hready; a hang is counted and ends the run
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         errors++;
         $display("ERROR t=%0t ready timeout", $time);
         report_and_stop();
      end
   endtask

   // One word transfer; the next call leaves an idle cycle
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] want);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      if (!w) exp_q.push_back(want);
      wait_rdy();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 32'h00000000);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      bus(1'b0, a, 32'h00000000, want);
   endtask

   // Exact tick counts by external rising edges
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge hclk);
         ext_clk_in <= 1'b1;
         repeat (4) @(posedge hclk);
         ext_clk_in <= 1'b0;
         repeat (3) @(posedge hclk);
      end
      repeat (4) @(posedge hclk);
   endtask

   // Cycles until pin a next changes, bounded
   task automatic pin_gap(output int n);
      logic p;
      p = pin_a_out;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (pin_a_out === p && n < 3000);
      if (n >= 3000) begin
         errors++;
         report_and_stop();
      end
   endtask

   function automatic logic [31:0] ctl(input logic [2:0] cs,
      input logic [2:0] wm, input logic [1:0] cb, input logic [1:0] ca);
      return {22'h000000, cs, wm, cb, ca};
   endfunction

   function automatic logic act(input logic s, input logic [1:0] code);
      case (code)
         2'd0: return s;
         2'd1: return ~s;
         2'd2: return 1'b0;
         default: return 1'b1;
      endcase
   endfunction

   // Read data meets the oldest note at its data phase edge
   always @(posedge hclk) begin
      if (rd_dp_ff && hreadyout === 1'b1) begin
         if (exp_q.size() == 0) chk(hrdata, 32'hFFFFFFFF);
         else chk(hrdata, exp_q.pop_front());
      end
      rd_dp_ff <= hsel && htrans[1] && hready && !hwrite;
   end

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      {hresetn, hsel, hwrite, ext_clk_in, rd_dp_ff} = 5'b00000;
      {haddr, hwdata, htrans, flag_ack, st} = '0;
      hsize = 3'b010;
      void'($urandom(18));
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (offs[i]) rd(offs[i], 32'h00000000);
      wr(8'h20, 32'hFFFFFFFF);
      rd(8'h20, 32'h00000000);
      $display("test reset done");
      wr(8'h08, 32'h10);
      wr(8'h0C, 32'h10);
      wr(8'h04, 32'hFD);
      wr(8'h00, ctl(3'd7, 3'd0, 2'd0, 2'd0));
      ticks(4);
      rd(8'h04, 32'h01);
      rd(8'h10, 32'h1);
      ticks(2);
      rd(8'h10, 32'h1);
      wr(8'h10, 32'h7);
      rd(8'h10, 32'h0);
      $display("test normal done");
      wr(8'h08, 32'h20);
      wr(8'h00, ctl(3'd0, 3'd0, 2'd0, 2'd0));
      wr(8'h04, 32'h20);
      repeat (10) @(posedge hclk);
      wr(8'h00, ctl(3'd7, 3'd0, 2'd0, 2'd0));
      ticks(1);
      rd(8'h10, 32'h0);
      rd(8'h04, 32'h21);
      wr(8'h04, 32'h1F);
      ticks(2);
      rd(8'h10, 32'h2);
      @(posedge hclk);
      flag_ack <= 3'b010;
      @(posedge hclk);
      flag_ack <= 3'b000;
      rd(8'h10, 32'h0);
      $display("test blocking done");
      foreach (codes[i]) begin
         wr(8'h00, ctl(3'd7, 3'd0, 2'd0, codes[i]));
         wr(8'h14, 32'h1);
         st[0] = act(st[0], codes[i]);
         rd(8'h14, {30'h0, st});
      end
      wr(8'h00, ctl(3'd7, 3'd0, 2'd3, 2'd0));
      wr(8'h14, 32'h2);
      st[1] = 1'b1;
      rd(8'h14, {30'h0, st});
      rd(8'h10, 32'h0);
      rd(8'h04, 32'h21);
      wr(8'h18, 32'h31);
      repeat (3) @(posedge hclk);
      chk(pin_a_oe, 1'b1);
      chk(pin_a_out, 1'b1);
      chk(pin_b_out, st[1]);
      wr(8'h00, ctl(3'd7, 3'd0, 2'd3, 2'd2));
      repeat (3) @(posedge hclk);
      chk(pin_a_out, st[0]);
      wr(8'h00, ctl(3'd7, 3'd3, 2'd3, 2'd2));
      rd(8'h14, {30'h0, st});
      repeat (3) @(posedge hclk);
      chk(pin_a_out, st[0]);
      $display("test outputs done");
      wr(8'h00, ctl(3'd7, 3'd2, 2'd0, 2'd1));
      wr(8'h08, 32'h3);
      wr(8'h04, 32'h0);
      wr(8'h10, 32'h7);
      ticks(4);
      st[0] = ~st[0];
      rd(8'h04, 32'h0);
      rd(8'h10, 32'h2);
      rd(8'h14, {30'h0, st});
      wr(8'h10, 32'h7);
      wr(8'h04, 32'hFE);
      ticks(2);
      rd(8'h04, 32'h0);
      rd(8'h10, 32'h1);
      ticks(4);
      st[0] = ~st[0];
      rd(8'h10, 32'h3);
      rd(8'h14, {30'h0, st});
      wr(8'h00, ctl(3'd7, 3'd2, 2'd0, 2'd3));
      ticks(4);
      st[0] = 1'b1;
      rd(8'h14, {30'h0, st});
      $display("test clear on match done");
      for (int p = 0; p < 3; p++) begin
         cmp = (p == 0) ? 0 : int'($urandom % 8);
         wr(8'h00, ctl(3'd0, 3'd2, 2'd0, 2'd1));
         wr(8'h04, 32'h0);
         wr(8'h08, cmp);
         wr(8'h00, ctl((p == 2) ? 3'd2 : 3'd1, 3'd2, 2'd0, 2'd1));
         if (p == 0) repeat (270) @(posedge hclk);
         pin_gap(gap);
         pin_gap(gap);
         chk(gap, ((p == 2) ? 8 : 1) * (1 + cmp));
      end
      $display("test frequency done");
      repeat (5) @(posedge hclk);
      chk(exp_q.size(), 0);
      report_and_stop();
   end
endmodule

// file: verif/tmr_checker.sv
`timescale 1ns/1ns
module tmr_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic ext_clk_in,
   input wire logic [2:0] flag_ack,
   input wire logic timer_tick,
   input wire logic pin_a_out,
   input wire logic pin_a_oe,
   input wire logic pin_b_out,
   input wire logic pin_b_oe
);
   logic wr_pend_ff;
   logic [7:0] wr_addr_ff;
   logic [9:0] ctrl_sh_ff;
   logic [7:0] cmpa_sh_ff;
   logic [5:0] port_sh_ff;
   logic [8:0] quiet_ff;

   // Write address phase, held for its data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
      end else begin
         wr_pend_ff <= hsel && htrans[1] && hready && hwrite;
         wr_addr_ff <= haddr[7:0];
      end
   end

   // Shadows of written registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_sh_ff <= 10'h000;
         cmpa_sh_ff <= 8'h00;
         port_sh_ff <= 6'h00;
      end else if (wr_pend_ff) begin
         if (wr_addr_ff == tmr_pkg::OFS_CTRL) ctrl_sh_ff <= hwdata[9:0];
         if (wr_addr_ff == tmr_pkg::OFS_CMPA) cmpa_sh_ff <= hwdata[7:0];
         if (wr_addr_ff == tmr_pkg::OFS_PORT) port_sh_ff <= hwdata[5:0];
      end
   end

   // Cycles since the last write; pins lag registers one edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) quiet_ff <= 9'h000;
      else if (wr_pend_ff) quiet_ff <= 9'h000;
      else if (quiet_ff != 9'h1FF) quiet_ff <= quiet_ff + 9'h001;
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // -------------------------------------------------------------
   // Bus and pin relations
   // -------------------------------------------------------------
   ready_high_a: assert property (hreadyout)
      else $error("ready low");
   resp_okay_a: assert property (!hresp)
      else $error("bad resp");
   unmapped_zero_a: assert property (hsel && htrans[1] && hready
      && !hwrite && haddr[7:0] > 8'h18 |=> hrdata == 32'h00000000)
      else $error("unmapped read");
   oe_a_dir_a: assert property (
      quiet_ff >= 9'd3 |-> pin_a_oe == port_sh_ff[4])
      else $error("pin a oe");
   oe_b_dir_a: assert property (
      quiet_ff >= 9'd3 |-> pin_b_oe == port_sh_ff[5])
      else $error("pin b oe");
   port_a_data_a: assert property (quiet_ff >= 9'd3
      && ctrl_sh_ff[1:0] == 2'b00 && port_sh_ff[4]
      |-> pin_a_out == port_sh_ff[0]) else $error("pin a data");
   port_b_data_a: assert property (quiet_ff >= 9'd3
      && ctrl_sh_ff[3:2] == 2'b00 && port_sh_ff[5]
      |-> pin_b_out == port_sh_ff[1]) else $error("pin b data");
   tick_run_a: assert property (
      quiet_ff >= 9'd3 && ctrl_sh_ff[9:7] == 3'd1 |-> timer_tick)
      else $error("tick missing");
   tick_stop_a: assert property (
      quiet_ff >= 9'd3 && ctrl_sh_ff[9:7] == 3'd0 |-> !timer_tick)
      else $error("stray tick");
   half_rate_a: assert property (quiet_ff >= 9'd260
      && ctrl_sh_ff == 10'h0A1 && cmpa_sh_ff == 8'h00 && port_sh_ff[4]
      |=> pin_a_out != $past(pin_a_out)) else $error("no toggle");

   cov_half_c: cover property (quiet_ff >= 9'd260 && ctrl_sh_ff == 10'h0A1);
   cov_oe_c: cover property ($rose(pin_a_oe));
   cov_unmap_c: cover property (hsel && htrans[1] && haddr[7:0] > 8'h18);
endmodule

bind tmr_timer8 tmr_checker tmr_checker_inst (.hclk, .hresetn, .hsel,
   .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
   .hrdata, .ext_clk_in, .flag_ack, .timer_tick, .pin_a_out, .pin_a_oe,
   .pin_b_out, .pin_b_oe);
